/* design/sac_conv_ctrl.sv */
// Successive-approximation converter control: registers, sequencing, results
`timescale 1ns/1ps
module sac_conv_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Trigger sources, same clock domain
    input wire logic [7:0] trig_in,
    // Analog core
    input wire logic [9:0] result_in,
    output sac_pkg::sac_core_s core,
    // Conversion complete interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic enable;
    logic pending;
    logic auto_en;
    logic flag;
    logic irq_en;
    logic [2:0] ps_sel;
    logic [2:0] ts_sel;
    logic ladj;
    sac_pkg::sac_sel_s sel_buf;
    sac_pkg::sac_sel_s sel_act;
    logic busy;
    logic first;
    logic [5:0] hcnt;
    logic [5:0] len_h;
    logic [5:0] sh_h;
    logic [9:0] result;
    logic blocked;
    logic trig_prev;
    logic [sac_pkg::TRIG_SYNC_CYCLES-1:0] trig_dly;
    logic tick_rise;
    logic tick_fall;
    logic phase;
    logic wr_csa;
    logic rd_lo;
    logic rd_hi;
    logic free_mode;
    logic trig_level;
    logic trig_edge;
    logic trig_go;
    logic tick_half;
    logic done;
    logic sample;
    logic user_go;
    logic restart_free;
    logic start_any;
    logic unlock;
    logic [5:0] next_len;
    logic [5:0] next_sh;

    ////////////////////////////////////////////////////////////////////////////
    // Decode and event terms

    assign wr_csa = wr && (addr == sac_pkg::OFS_CSA);
    assign rd_lo = rd && (addr == sac_pkg::OFS_RES_LO);
    assign rd_hi = rd && (addr == sac_pkg::OFS_RES_HI);
    assign free_mode = auto_en && (ts_sel == sac_pkg::TRIG_FREE_RUN);
    assign trig_level = (ts_sel == sac_pkg::TRIG_FREE_RUN) ? flag : trig_in[ts_sel];
    assign tick_half = tick_rise || tick_fall;

    // Rising trigger edges only, dropped while converting
    assign trig_edge = enable && auto_en && !free_mode && trig_level && !trig_prev
        && !busy;
    assign trig_go = trig_dly[sac_pkg::TRIG_SYNC_CYCLES-1] && enable && !busy;

    // Completion and sample instants counted in half cycles
    assign done = busy && tick_half && ((hcnt + 6'h01) == len_h);
    assign sample = busy && tick_half && ((hcnt + 6'h01) == sh_h);

    // User start waits for a converter rising edge
    assign user_go = enable && pending && !busy && tick_rise;
    assign restart_free = done && free_mode;
    assign start_any = user_go || trig_go || restart_free;

    // Selection follows the buffer until locked, free again in last cycle
    assign unlock = !busy || (hcnt >= (len_h - sac_pkg::HALF_LAST_CYCLE));

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler

    sac_prescaler u_presc (
        .clk(clk),
        .rst(rst),
        .run(enable),
        .restart(trig_go),
        .div_sel(ps_sel),
        .tick_rise(tick_rise),
        .tick_fall(tick_fall),
        .phase(phase)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    // Control A fields other than start and flag
    always_ff @(posedge clk) begin
        if (rst) begin
            enable <= 1'b0;
            auto_en <= 1'b0;
            irq_en <= 1'b0;
            ps_sel <= 3'h0;
        end else if (wr_csa) begin
            enable <= wdata[sac_pkg::CSA_EN];
            auto_en <= wdata[sac_pkg::CSA_AUTO];
            irq_en <= wdata[sac_pkg::CSA_IE];
            ps_sel <= wdata[sac_pkg::CSA_PS_LSB +: 3];
        end
    end

    // Control B and channel selection buffer
    always_ff @(posedge clk) begin
        if (rst) begin
            ts_sel <= 3'h0;
            ladj <= 1'b0;
            sel_buf <= '0;
        end else if (wr && (addr == sac_pkg::OFS_CSB)) begin
            ts_sel <= wdata[sac_pkg::CSB_TS_LSB +: 3];
        end else if (wr && (addr == sac_pkg::OFS_CHSEL)) begin
            ladj <= wdata[sac_pkg::CHSEL_LADJ];
            sel_buf.refsel <= wdata[sac_pkg::CHSEL_REF_LSB +: 2];
            sel_buf.channel_mux_field <= wdata[sac_pkg::CHSEL_MUX_LSB +: 5];
        end
    end

    // Pending user start; a start already happening satisfies the write
    always_ff @(posedge clk) begin
        if (rst || start_any || (!enable && !wr_csa)) begin
            pending <= 1'b0;
        end else if (wr_csa && !wdata[sac_pkg::CSA_EN]) begin
            pending <= 1'b0;
        end else if (wr_csa && wdata[sac_pkg::CSA_START] && !busy) begin
            pending <= 1'b1;
        end
    end

    // Completion flag: a completion wins over a write-one clear
    always_ff @(posedge clk) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (done) begin
            flag <= 1'b1;
        end else if (wr_csa && wdata[sac_pkg::CSA_FLAG]) begin
            flag <= 1'b0;
        end
    end

    assign irq = flag && irq_en;

    ////////////////////////////////////////////////////////////////////////////
    // Trigger detection

    // Edge history and synchronisation delay line
    always_ff @(posedge clk) begin
        if (rst) begin
            trig_prev <= 1'b0;
            trig_dly <= '0;
        end else begin
            trig_prev <= trig_level;
            trig_dly <= {trig_dly[sac_pkg::TRIG_SYNC_CYCLES-2:0], trig_edge};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencing

    // Length and sample point chosen at the start
    always_comb begin
        if (first && !done) begin
            next_len = sac_pkg::HALF_LEN_FIRST;
            next_sh = sac_pkg::HALF_SH_FIRST;
        end else if (trig_go) begin
            next_len = sac_pkg::HALF_LEN_AUTO;
            next_sh = sac_pkg::HALF_SH_AUTO;
        end else if (sac_pkg::is_diff(sel_buf.channel_mux_field) && (restart_free || phase)) begin
            next_len = sac_pkg::HALF_LEN_DIFF;
            next_sh = sac_pkg::HALF_SH_DIFF;
        end else begin
            next_len = sac_pkg::HALF_LEN_NORMAL;
            next_sh = sac_pkg::HALF_SH_NORMAL;
        end
    end

    // Busy marks a running conversion; disable aborts it
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            busy <= 1'b0;
        end else if (start_any) begin
            busy <= 1'b1;
        end else if (done) begin
            busy <= 1'b0;
        end
    end

    // Half-cycle counter and timing of the current conversion
    always_ff @(posedge clk) begin
        if (rst) begin
            hcnt <= 6'h00;
            len_h <= sac_pkg::HALF_LEN_NORMAL;
            sh_h <= sac_pkg::HALF_SH_NORMAL;
        end else if (start_any) begin
            hcnt <= 6'h00;
            len_h <= next_len;
            sh_h <= next_sh;
        end else if (busy && tick_half) begin
            hcnt <= hcnt + 6'h01;
        end
    end

    // First conversion after enable is the long one
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            first <= 1'b1;
        end else if (done) begin
            first <= 1'b0;
        end
    end

    // Active selection copied only while enabled and unlocked
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_act <= '0;
        end else if (enable && unlock) begin
            sel_act <= sel_buf;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result capture

    // Low-byte read blocks, high-byte read releases
    always_ff @(posedge clk) begin
        if (rst) begin
            blocked <= 1'b0;
        end else if (rd_hi) begin
            blocked <= 1'b0;
        end else if (rd_lo) begin
            blocked <= 1'b1;
        end
    end

    // A completion during a low read is also discarded
    always_ff @(posedge clk) begin
        if (rst) begin
            result <= sac_pkg::RST_RESULT;
        end else if (done && !blocked && !rd_lo) begin
            result <= result_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read

    // Read data valid the cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (rst || !rd) begin
            rdata <= sac_pkg::RST_BYTE;
        end else begin
            unique case (addr)
                sac_pkg::OFS_CSA: begin
                    rdata <= {enable, busy || pending, auto_en, flag, irq_en,
                        ps_sel};
                end
                sac_pkg::OFS_CSB: begin
                    rdata <= {5'h00, ts_sel};
                end
                sac_pkg::OFS_CHSEL: begin
                    rdata <= {sel_buf.refsel, ladj, sel_buf.channel_mux_field};
                end
                sac_pkg::OFS_RES_LO: begin
                    rdata <= ladj ? {result[1:0], 6'h00} : result[7:0];
                end
                sac_pkg::OFS_RES_HI: begin
                    rdata <= ladj ? result[9:2] : {6'h00, result[9:8]};
                end
                default: begin
                    rdata <= sac_pkg::RST_BYTE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Analog core controls

    assign core.start = start_any;
    assign core.sample = sample;
    assign core.done = done;
    assign core.clk_en = tick_rise;
    assign core.phase = phase;
    assign core.gain = sac_pkg::gain_of(sel_act.channel_mux_field);
    assign core.sel = sel_act;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_done_clears_busy: assert property (done && !free_mode |=> !busy)
        else $error("busy still set after single conversion");

    a_free_keeps_busy: assert property (done && free_mode && enable |=> busy)
        else $error("free-running conversion did not restart");

    a_blocked_result: assert property (blocked && !rd_hi |=> $stable(result))
        else $error("result changed while blocked");

    a_high_releases: assert property (rd_hi |=> !blocked)
        else $error("high byte read did not release");

    a_flag_on_done: assert property (done |=> flag)
        else $error("flag not set at completion");

    a_disabled_prescaler: assert property (!enable |-> !tick_rise && !tick_fall)
        else $error("prescaler ran while disabled");

    a_sel_locked: assert property (busy && !unlock && $past(busy) |=> $stable(sel_act))
        else $error("selection moved during conversion");

    a_no_busy_trigger: assert property (busy && !done |-> !start_any)
        else $error("conversion started while busy");

    a_first_length: assert property (start_any && first && !done |=> len_h == 6'h32)
        else $error("first conversion length wrong");

    a_trigger_sync: assert property (trig_edge ##1 !busy ##1 !busy ##1 (!busy && enable)
        |-> trig_go)
        else $error("trigger start not three cycles after edge");

    a_user_on_rise: assert property (user_go |-> tick_rise)
        else $error("user start off the converter rising edge");

endmodule

/* design/sac_pkg.sv */
// Constants, types and decode helpers for the converter control block
package sac_pkg;

    // Register offsets on the plain register port
    localparam logic [2:0] OFS_CSA = 3'h0;
    localparam logic [2:0] OFS_CSB = 3'h1;
    localparam logic [2:0] OFS_CHSEL = 3'h2;
    localparam logic [2:0] OFS_RES_LO = 3'h3;
    localparam logic [2:0] OFS_RES_HI = 3'h4;

    // Field positions in control_status_a
    localparam int CSA_EN = 7;
    localparam int CSA_START = 6;
    localparam int CSA_AUTO = 5;
    localparam int CSA_FLAG = 4;
    localparam int CSA_IE = 3;
    localparam int CSA_PS_LSB = 0;

    // Field positions in control_status_b and channel_select_register
    localparam int CSB_TS_LSB = 0;
    localparam int CHSEL_REF_LSB = 6;
    localparam int CHSEL_LADJ = 5;
    localparam int CHSEL_MUX_LSB = 0;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [9:0] RST_RESULT = 10'h000;

    // Conversion timing in converter clock half cycles
    localparam logic [5:0] HALF_LEN_NORMAL = 6'h1A;
    localparam logic [5:0] HALF_SH_NORMAL = 6'h03;
    localparam logic [5:0] HALF_LEN_FIRST = 6'h32;
    localparam logic [5:0] HALF_SH_FIRST = 6'h1B;
    localparam logic [5:0] HALF_LEN_AUTO = 6'h1B;
    localparam logic [5:0] HALF_SH_AUTO = 6'h04;
    localparam logic [5:0] HALF_LEN_DIFF = 6'h1C;
    localparam logic [5:0] HALF_SH_DIFF = 6'h05;
    localparam logic [5:0] HALF_LAST_CYCLE = 6'h02;

    // Trigger handling
    localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
    localparam int TRIG_SYNC_CYCLES = 3;

    // Gain stage settings
    typedef enum logic [1:0] {
        GAIN_BYPASS,
        GAIN_1X,
        GAIN_10X,
        GAIN_200X
    } sac_gain_e;

    // Channel and reference selection
    typedef struct packed {
        logic [1:0] refsel;
        logic [4:0] channel_mux_field;
    } sac_sel_s;

    // Controls toward the analog core
    typedef struct packed {
        logic start;
        logic sample;
        logic done;
        logic clk_en;
        logic phase;
        sac_gain_e gain;
        sac_sel_s sel;
    } sac_core_s;

    // Channel codes from 8 upward are differential
    function automatic logic is_diff(input logic [4:0] channel_mux_field);
        is_diff = channel_mux_field[4] | channel_mux_field[3];
    endfunction

    // Gain pairs: 08..09 at 10x, 0A..0B at 200x, 0C..0D at 1x
    function automatic sac_gain_e gain_of(input logic [4:0] channel_mux_field);
        if (!is_diff(channel_mux_field)) begin
            gain_of = GAIN_BYPASS;
        end else if (channel_mux_field[4:1] == 4'h4) begin
            gain_of = GAIN_10X;
        end else if (channel_mux_field[4:1] == 4'h5) begin
            gain_of = GAIN_200X;
        end else begin
            gain_of = GAIN_1X;
        end
    endfunction

endpackage

/* design/sac_prescaler.sv */
// Converter clock prescaler producing rising and falling edge enables
`timescale 1ns/1ps
module sac_prescaler (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic restart,
    input wire logic [2:0] div_sel,
    // Converter clock edges and phase
    output logic tick_rise,
    output logic tick_fall,
    output logic phase
);

    logic [6:0] cnt;
    logic [6:0] last;

    // Terminal count: settings 0 and 1 divide by 2, then powers of two
    always_comb begin
        if (div_sel == 3'h0) begin
            last = 7'h01;
        end else begin
            last = 7'((8'h01 << div_sel) - 8'h01);
        end
    end

    // Counter held at zero while disabled or on a trigger restart
    always_ff @(posedge clk) begin
        if (rst || !run || restart) begin
            cnt <= 7'h00;
        end else if (cnt >= last) begin
            cnt <= 7'h00;
        end else begin
            cnt <= cnt + 7'h01;
        end
    end

    assign tick_rise = run && !restart && (cnt >= last);
    assign tick_fall = run && !restart && (cnt == (last >> 1));

    // Half-rate phase clock, low after enable
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            phase <= 1'b0;
        end else if (tick_rise) begin
            phase <= !phase;
        end
    end

endmodule

/* bench/sac_core_model.sv */
// Behavioural analog core answering the converter control block
`timescale 1ns/1ps
module sac_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controls from the block
    input wire sac_pkg::sac_core_s core,
    // Conversion result
    output logic [9:0] result_in
);
    logic [4:0] held_mux;
    logic [4:0] seq;
    logic [9:0] last;

    // Channel taken at the sample instant, count advanced per completion
    always_ff @(posedge clk) begin
        if (rst) begin
            held_mux <= 5'h00;
            seq <= 5'h01;
            last <= 10'h000;
        end else begin
            if (core.sample) begin
                held_mux <= core.sel.channel_mux_field;
            end
            if (core.done) begin
                seq <= seq + 5'h01;
                last <= {held_mux, seq};
            end
        end
    end

    // Result only valid in the completion cycle, inverted otherwise
    assign result_in = core.done ? {held_mux, seq} : ~last;
endmodule

/* bench/tb_sar_adc_conversion_control.sv */
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
module tb_sar_adc_conversion_control;
    logic clk;
    logic rst;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic [7:0] trig_in;
    logic [9:0] result_in;
    sac_pkg::sac_core_s core;
    logic irq;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [4:0] sq = 5'h01;
    logic [9:0] exp_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Design and analog core model
    sac_conv_ctrl dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .trig_in(trig_in), .result_in(result_in), .core(core), .irq(irq));
    sac_core_model core_model (.clk(clk), .rst(rst), .core(core), .result_in(result_in));

    // Clock and cycle count
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask

    // Waits for start (0), sample (1) or done (2); cycle stamp or -1
    task automatic wait_ev(input int k, input int lim, output int t);
        logic hit;
        hit = 1'b0;
        t = -1;
        for (int i = 0; i < lim && !hit; i++) begin
            @(posedge clk);
            hit = (k == 0) ? core.start : ((k == 1) ? core.sample : core.done);
        end
        if (hit === 1'b1) t = cyc;
    endtask

    task automatic count_en(input int span, output int ne);
        ne = 0;
        repeat (span) begin
            @(posedge clk);
            if (core.clk_en === 1'b1) ne++;
        end
    endtask

    // One conversion with timing figures in system cycles (prescale /2)
    task automatic conv(input logic [4:0] channel_mux_field, input int sh, input int len, input logic [7:0] mid);
        int ts;
        int tsm;
        int td;
        exp_r = {channel_mux_field, sq};
        sq = sq + 5'h01;
        wait_ev(0, 20, ts);
        chk("start_on_tick", 1'b1, core.clk_en);
        if (mid != 8'h00) wr_reg(sac_pkg::OFS_CHSEL, mid);
        wait_ev(1, 60, tsm);
        wait_ev(2, 60, td);
        chk("sample_at", 10'(sh), 10'(tsm - ts));
        chk("done_at", 10'(len), 10'(td - ts));
    endtask

    task automatic chk_res(input logic [9:0] r, input logic ladj);
        logic [7:0] lo;
        logic [7:0] hi;
        rd_reg(sac_pkg::OFS_RES_LO, lo);
        rd_reg(sac_pkg::OFS_RES_HI, hi);
        chk("res_lo", ladj ? {r[1:0], 6'h00} : r[7:0], lo);
        chk("res_hi", ladj ? r[9:2] : {6'h00, r[9:8]}, hi);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        logic [7:0] v;
        for (int a = 0; a < 6; a++) begin
            rd_reg(3'(a), v);
            chk("reg_reset", 8'h00, v);
        end
        chk("irq_reset", 1'b0, irq);
    endtask

    task automatic t_first;
        logic [7:0] v;
        int ne;
        wr_reg(sac_pkg::OFS_CHSEL, 8'h43);
        count_en(10, ne);
        chk("tick_disabled", 0, ne);
        chk("sel_disabled", 7'h00, core.sel);
        chk("phase_disabled", 1'b0, core.phase);
        wr_reg(sac_pkg::OFS_CSA, 8'h80);
        count_en(4, ne);
        count_en(20, ne);
        chk("tick_enabled", 10, ne);
        // Half-rate phase flips once per converter clock
        v[0] = core.phase;
        repeat (2) @(posedge clk);
        chk("phase_toggle", !v[0], core.phase);
        chk("sel_enabled", 7'h23, core.sel);
        wr_reg(sac_pkg::OFS_CSA, 8'hC0);
        conv(5'h03, 27, 50, 8'h00);
        rd_reg(sac_pkg::OFS_CSA, v);
        chk("start_cleared", 1'b0, v[6]);
        chk("flag_set", 1'b1, v[4]);
        chk_res(exp_r, 1'b0);
        wr_reg(sac_pkg::OFS_CHSEL, 8'h65);
        wr_reg(sac_pkg::OFS_CSA, 8'hC0);
        conv(5'h05, 3, 26, 8'h00);
        chk_res(exp_r, 1'b1);
    endtask

    task automatic t_lock;
        logic [7:0] v;
        logic [9:0] held;
        held = exp_r;
        rd_reg(sac_pkg::OFS_RES_LO, v);
        wr_reg(sac_pkg::OFS_CSA, 8'h98);
        wr_reg(sac_pkg::OFS_CSA, 8'hC8);
        conv(5'h05, 3, 26, 8'h00);
        @(posedge clk);
        chk("irq_discarded", 1'b1, irq);
        rd_reg(sac_pkg::OFS_RES_HI, v);
        chk("hi_blocked", held[9:2], v);
        wr_reg(sac_pkg::OFS_CSA, 8'h98);
        @(posedge clk);
        chk("irq_cleared", 1'b0, irq);
        wr_reg(sac_pkg::OFS_CSA, 8'hC0);
        conv(5'h05, 3, 26, 8'h26);
        chk_res(exp_r, 1'b1);
        wr_reg(sac_pkg::OFS_CSA, 8'hC0);
        conv(5'h06, 3, 26, 8'h00);
        chk_res(exp_r, 1'b1);
    endtask

    task automatic t_auto;
        logic [7:0] v;
        int t0;
        int ts;
        int tsm;
        int td;
        wr_reg(sac_pkg::OFS_CSA, 8'hA0);
        for (int n = 1; n < 8; n++) begin
            wr_reg(sac_pkg::OFS_CSB, 8'(n));
            @(posedge clk);
            trig_in <= 8'hFE & ~(8'h01 << n);
            wait_ev(0, 20, ts);
            chk("other_source", 1'b0, ts != -1);
            trig_in <= 8'hFE;
            t0 = cyc;
            wait_ev(0, 20, ts);
            chk("trig_to_start", 4, 10'(ts - t0));
            wait_ev(1, 20, tsm);
            chk("auto_sample", 4, 10'(tsm - ts));
            rd_reg(sac_pkg::OFS_CSA, v);
            chk("busy_auto", 1'b1, v[6]);
            trig_in <= 8'h00;
            @(posedge clk);
            trig_in <= 8'hFE;
            wait_ev(2, 60, td);
            chk("auto_done", 27, 10'(td - ts));
            wait_ev(0, 60, ts);
            chk("no_retrigger", 1'b1, ts == -1);
            trig_in <= 8'h00;
            sq = sq + 5'h01;
        end
    endtask

    task automatic t_free;
        logic [7:0] v;
        int td;
        int tp;
        wr_reg(sac_pkg::OFS_CSB, 8'h00);
        wr_reg(sac_pkg::OFS_CSA, 8'h00);
        wr_reg(sac_pkg::OFS_CHSEL, 8'h0C);
        // Enable and start in one write, on a differential channel
        wr_reg(sac_pkg::OFS_CSA, 8'hE0);
        for (int i = 0; i < 3; i++) begin
            tp = td;
            wait_ev(2, 120, td);
            chk("restart", 1'b1, core.start);
            if (i > 0) chk("free_diff_len", 28, 10'(td - tp));
        end
        rd_reg(sac_pkg::OFS_CSA, v);
        chk("start_held", 1'b1, v[6]);
        wr_reg(sac_pkg::OFS_CSA, 8'h00);
    endtask

    task automatic t_gain;
        logic [4:0] mx [4] = '{5'h03, 5'h08, 5'h0A, 5'h0C};
        sac_pkg::sac_gain_e g [4] = '{sac_pkg::GAIN_BYPASS, sac_pkg::GAIN_10X,
            sac_pkg::GAIN_200X, sac_pkg::GAIN_1X};
        int ne;
        // Slowest prescale keeps the converter clock inside its accuracy range
        wr_reg(sac_pkg::OFS_CSA, 8'h87);
        for (int i = 0; i < 4; i++) begin
            wr_reg(sac_pkg::OFS_CHSEL, {3'h0, mx[i]});
            repeat (3) @(posedge clk);
            chk("gain", g[i], core.gain);
        end
        count_en(256, ne);
        chk("tick_slow", 2, ne);
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        addr = 3'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        trig_in = 8'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_first();
        t_lock();
        t_auto();
        t_free();
        t_gain();
        summarize();
    end

    // Watchdog against a hang
    initial begin
        repeat (8000) @(posedge clk);
        n_errors++;
        $display("FAIL watchdog expected finish seen timeout");
        summarize();
    end
endmodule
